// [rtl/ect_pkg.sv]
package ect_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 16;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CNT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_CNT_VALUE = 8'h08;
  localparam logic [7:0] ADDR_CNT_SNAP = 8'h0C;
  localparam logic [7:0] ADDR_CNT_CMD = 8'h10;
  localparam logic [7:0] ADDR_TMR_SEL = 8'h14;
  localparam logic [7:0] ADDR_TMR_CFG = 8'h18;
  localparam logic [7:0] ADDR_TMR_LEN = 8'h1C;
  localparam logic [7:0] ADDR_TMR_VALUE = 8'h20;
  localparam logic [7:0] ADDR_TMR_STATE = 8'h24;
  localparam logic [7:0] ADDR_TMR_CMD = 8'h28;
  // ==========================================================================
  // Field positions
  localparam int CLR_SRC_LSB = 0;
  localparam int CLR_EDGE_LSB = 8;
  localparam int INC_SEL_LSB = 12;
  localparam int TMR_MODE_BIT = 0;
  localparam int TMR_SRC_LSB = 4;
  localparam int TMR_EDGE_LSB = 12;
  localparam int CMD_BIT = 0;
  // ==========================================================================
  // Encodings and reset values
  localparam logic [1:0] TMR_ID_ONE = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_ANY = 2'h2;
  localparam logic [1:0] INC_OFF = 2'h0;
  localparam logic [1:0] INC_TICK = 2'h1;
  localparam logic [1:0] INC_EVENT = 2'h2;
  localparam logic [31:0] CNT_LIMIT_RST = 32'h0000_0001;
  localparam logic [31:0] TMR_LEN_RST = 32'h0000_0001;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef enum logic [4:0] {
    SRC_OFF = 5'h00, SRC_ACQ_START = 5'h01, SRC_ACQ_END = 5'h02,
    SRC_EXP_START = 5'h03, SRC_EXP_END = 5'h04, SRC_RO_START = 5'h05,
    SRC_RO_END = 5'h06, SRC_FRAME_START = 5'h07, SRC_VALID_TRIG = 5'h08,
    SRC_REJECT_TRIG = 5'h09, SRC_BURST_END = 5'h0A, SRC_BROADCAST_CMD_ONE = 5'h0B,
    SRC_BROADCAST_CMD_TWO = 5'h0C, SRC_LINE1 = 5'h0D, SRC_LINE2 = 5'h0E,
    SRC_TMR_END = 5'h0F, SRC_CNT_END = 5'h10, SRC_CYCLE_FIRST = 5'h11
  } ect_src_t;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'h0, TMR_ARMED = 2'h1, TMR_RUN = 2'h2, TMR_DONE = 2'h3
  } ect_tmr_state_t;
endpackage

// [rtl/ect_top.sv]
`timescale 1ns/10ps
module ect_top #(
  parameter int TICK_CYCLES = ect_pkg::TICK_CYCLES,
  parameter int CYC_W = 4
) (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic acq_start, // Acquisition start pulse
  input wire logic acq_end, // Acquisition end pulse
  input wire logic exp_start, // Exposure start pulse
  input wire logic exp_end, // Exposure end pulse
  input wire logic readout_start, // Readout start pulse
  input wire logic readout_end, // Readout end pulse
  input wire logic frame_start, // Frame start pulse
  input wire logic accepted_frame_trigger, // Valid trigger pulse
  input wire logic rejected_frame_trigger, // Rejected trigger pulse
  input wire logic multi_frame_finish_event, // Burst end pulse
  input wire logic broadcast_cmd_one, // Action command 1 pulse
  input wire logic broadcast_cmd_two, // Action command 2 pulse
  input wire logic cycle_first_frame, // Level: current frame is first
  input wire logic [CYC_W-1:0] cycle_active_set, // Cycling active set
  input wire logic count_inc_event, // Increment event pulse
  input wire logic count_start_event, // Counter start pulse
  input wire logic [1:0] line_in, // Input lines 1 and 2
  output logic count_done_event, // Counter end pulse
  output logic tmr_done_event // Timer end pulse
);

  typedef struct packed {
    logic [1:0][2:0] line_sh;
    logic [ect_pkg::TICK_W-1:0] tick_cnt;
    logic tick;
    logic [4:0] clr_src;
    logic [1:0] clr_edge;
    logic [1:0] inc_sel;
    logic [31:0] cnt_limit;
    logic [31:0] cnt_value;
    logic [31:0] cnt_snap;
    logic cnt_run;
    logic cnt_done;
    logic [1:0] tmr_sel;
    logic tmr_mode;
    logic [4:0] tmr_src;
    logic [1:0] tmr_edge;
    logic [31:0] tmr_len;
    logic [31:0] tmr_val;
    ect_pkg::ect_tmr_state_t tmr_state;
    logic tmr_done;
    logic [31:0] rdata;
    logic err;
  } ect_state_t;

  ect_state_t s;
  ect_state_t next_s;
  logic [1:0] rise;
  logic [1:0] fall;
  logic setup;
  logic wr;
  logic cnt_cmd;
  logic tmr_cmd;
  logic tmr_ok;
  logic clr_fire;
  logic start_fire;
  logic inc;
  logic [31:0] cnt_plus;
  logic [31:0] tmr_plus;
  logic cycle_fire;

  // ==========================================================================
  // Line edge strobes
  for (genvar i = 0; i < 2; i++)
  begin : g_line
    assign rise[i] = s.line_sh[i][1] & ~s.line_sh[i][2];
    assign fall[i] = ~s.line_sh[i][1] & s.line_sh[i][2];
  end

  function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
    edge_pick = (sel == ect_pkg::EDGE_RISE) ? r :
                (sel == ect_pkg::EDGE_FALL) ? f :
                (sel == ect_pkg::EDGE_ANY) ? (r | f) : 1'b0;
  endfunction

  // Shared source decode for counter clear and timer start
  function automatic logic src_pick(input logic [4:0] code, input logic [1:0] edg,
                                    input logic cyc);
    src_pick = 1'b0;
    unique case (code)
      ect_pkg::SRC_ACQ_START: src_pick = acq_start;
      ect_pkg::SRC_ACQ_END: src_pick = acq_end;
      ect_pkg::SRC_EXP_START: src_pick = exp_start;
      ect_pkg::SRC_EXP_END: src_pick = exp_end;
      ect_pkg::SRC_RO_START: src_pick = readout_start;
      ect_pkg::SRC_RO_END: src_pick = readout_end;
      ect_pkg::SRC_FRAME_START: src_pick = frame_start;
      ect_pkg::SRC_VALID_TRIG: src_pick = accepted_frame_trigger;
      ect_pkg::SRC_REJECT_TRIG: src_pick = rejected_frame_trigger;
      ect_pkg::SRC_BURST_END: src_pick = multi_frame_finish_event;
      ect_pkg::SRC_BROADCAST_CMD_ONE: src_pick = broadcast_cmd_one;
      ect_pkg::SRC_BROADCAST_CMD_TWO: src_pick = broadcast_cmd_two;
      ect_pkg::SRC_LINE1: src_pick = edge_pick(edg, rise[0], fall[0]);
      ect_pkg::SRC_LINE2: src_pick = edge_pick(edg, rise[1], fall[1]);
      ect_pkg::SRC_TMR_END: src_pick = s.tmr_done;
      ect_pkg::SRC_CNT_END: src_pick = s.cnt_done;
      ect_pkg::SRC_CYCLE_FIRST: src_pick = cyc;
      default: src_pick = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // Decode and next state
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign cnt_cmd = wr && paddr == ect_pkg::ADDR_CNT_CMD && pwdata[ect_pkg::CMD_BIT];
  assign tmr_ok = s.tmr_sel == ect_pkg::TMR_ID_ONE;
  assign tmr_cmd = wr && tmr_ok && paddr == ect_pkg::ADDR_TMR_CMD && pwdata[ect_pkg::CMD_BIT];
  assign cycle_fire = frame_start & cycle_first_frame
                      & (cycle_active_set == CYC_W'(1));
  // Procedural, so that the event pins read inside src_pick wake the decode
  always_comb
  begin
    clr_fire = s.clr_src != ect_pkg::SRC_OFF
               && s.clr_src != ect_pkg::SRC_BROADCAST_CMD_ONE
               && s.clr_src != ect_pkg::SRC_BROADCAST_CMD_TWO
               && s.clr_src != ect_pkg::SRC_CYCLE_FIRST
               && src_pick(s.clr_src, s.clr_edge, 1'b0);
    start_fire = src_pick(s.tmr_src, s.tmr_edge, cycle_fire)
                 && s.tmr_src != ect_pkg::SRC_REJECT_TRIG;
  end
  assign inc = s.cnt_run && ((s.inc_sel == ect_pkg::INC_TICK && s.tick)
               || (s.inc_sel == ect_pkg::INC_EVENT && count_inc_event));
  assign cnt_plus = s.cnt_value + 32'h0000_0001;
  assign tmr_plus = s.tmr_val + 32'h0000_0001;

  always_comb
  begin
    next_s = s;
    next_s.cnt_done = 1'b0;
    next_s.tmr_done = 1'b0;
    next_s.tick = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      next_s.line_sh[i] = {s.line_sh[i][1:0], line_in[i]};
    end
    // Microsecond time base
    if (s.tick_cnt == ect_pkg::TICK_W'(TICK_CYCLES - 1))
    begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.tick_cnt = s.tick_cnt + ect_pkg::TICK_W'(1);
    end
    // Register writes
    if (wr)
    begin
      unique case (paddr)
        ect_pkg::ADDR_CNT_CTRL:
        begin
          next_s.clr_src = pwdata[ect_pkg::CLR_SRC_LSB +: 5];
          next_s.clr_edge = pwdata[ect_pkg::CLR_EDGE_LSB +: 2];
          next_s.inc_sel = pwdata[ect_pkg::INC_SEL_LSB +: 2];
        end
        ect_pkg::ADDR_CNT_LIMIT: next_s.cnt_limit = pwdata;
        ect_pkg::ADDR_TMR_SEL: next_s.tmr_sel = pwdata[1:0];
        ect_pkg::ADDR_TMR_CFG:
        begin
          if (tmr_ok)
          begin
            next_s.tmr_mode = pwdata[ect_pkg::TMR_MODE_BIT];
            if (!s.tmr_mode)
            begin
              next_s.tmr_src = pwdata[ect_pkg::TMR_SRC_LSB +: 5];
              next_s.tmr_edge = pwdata[ect_pkg::TMR_EDGE_LSB +: 2];
            end
          end
        end
        ect_pkg::ADDR_TMR_LEN:
        begin
          if (tmr_ok && !s.tmr_mode)
          begin
            next_s.tmr_len = pwdata;
          end
        end
        default: ;
      endcase
    end
    // Counter
    if (cnt_cmd)
    begin
      next_s.cnt_snap = s.cnt_value;
      next_s.cnt_value = ZERO32_F();
      next_s.cnt_run = 1'b1;
    end
    else if (clr_fire)
    begin
      next_s.cnt_snap = s.cnt_value;
      next_s.cnt_value = ZERO32_F();
      next_s.cnt_run = 1'b0;
    end
    else
    begin
      if (count_start_event)
      begin
        next_s.cnt_run = 1'b1;
      end
      if (inc)
      begin
        next_s.cnt_value = cnt_plus;
        next_s.cnt_done = cnt_plus == s.cnt_limit;
      end
    end
    // Timer
    if (!s.tmr_mode)
    begin
      next_s.tmr_state = ect_pkg::TMR_IDLE;
      next_s.tmr_val = ZERO32_F();
    end
    else
    begin
      unique case (s.tmr_state)
        ect_pkg::TMR_IDLE, ect_pkg::TMR_ARMED, ect_pkg::TMR_DONE:
        begin
          if (s.tmr_src == ect_pkg::SRC_OFF)
          begin
            if (tmr_cmd)
            begin
              next_s.tmr_state = ect_pkg::TMR_RUN;
              next_s.tmr_val = ZERO32_F();
            end
            else if (s.tmr_state == ect_pkg::TMR_ARMED)
            begin
              next_s.tmr_state = ect_pkg::TMR_IDLE;
            end
          end
          else if (start_fire)
          begin
            next_s.tmr_state = ect_pkg::TMR_RUN;
            next_s.tmr_val = ZERO32_F();
          end
          else if (s.tmr_state == ect_pkg::TMR_IDLE)
          begin
            next_s.tmr_state = ect_pkg::TMR_ARMED;
          end
        end
        ect_pkg::TMR_RUN:
        begin
          if (tmr_cmd)
          begin
            next_s.tmr_val = ZERO32_F();
            next_s.tmr_state = (s.tmr_src == ect_pkg::SRC_OFF) ?
                               ect_pkg::TMR_RUN : ect_pkg::TMR_ARMED;
          end
          else if (s.tick)
          begin
            next_s.tmr_val = tmr_plus;
            if (tmr_plus >= s.tmr_len)
            begin
              next_s.tmr_state = ect_pkg::TMR_DONE;
              next_s.tmr_done = 1'b1;
            end
          end
        end
      endcase
    end
    // Read data captured in the setup phase
    next_s.rdata = ZERO32_F();
    next_s.err = 1'b0;
    if (setup)
    begin
      unique case (paddr)
        ect_pkg::ADDR_CNT_CTRL:
        begin
          next_s.rdata[ect_pkg::CLR_SRC_LSB +: 5] = s.clr_src;
          next_s.rdata[ect_pkg::CLR_EDGE_LSB +: 2] = s.clr_edge;
          next_s.rdata[ect_pkg::INC_SEL_LSB +: 2] = s.inc_sel;
        end
        ect_pkg::ADDR_CNT_LIMIT: next_s.rdata = s.cnt_limit;
        ect_pkg::ADDR_CNT_VALUE: next_s.rdata = s.cnt_value;
        ect_pkg::ADDR_CNT_SNAP: next_s.rdata = s.cnt_snap;
        ect_pkg::ADDR_CNT_CMD, ect_pkg::ADDR_TMR_CMD: ;
        ect_pkg::ADDR_TMR_SEL: next_s.rdata[1:0] = s.tmr_sel;
        ect_pkg::ADDR_TMR_CFG:
        begin
          if (tmr_ok)
          begin
            next_s.rdata[ect_pkg::TMR_MODE_BIT] = s.tmr_mode;
            next_s.rdata[ect_pkg::TMR_SRC_LSB +: 5] = s.tmr_src;
            next_s.rdata[ect_pkg::TMR_EDGE_LSB +: 2] = s.tmr_edge;
          end
        end
        ect_pkg::ADDR_TMR_LEN: next_s.rdata = tmr_ok ? s.tmr_len : ZERO32_F();
        ect_pkg::ADDR_TMR_VALUE: next_s.rdata = tmr_ok ? s.tmr_val : ZERO32_F();
        ect_pkg::ADDR_TMR_STATE: next_s.rdata[1:0] = tmr_ok ? s.tmr_state : 2'h0;
        default: next_s.err = 1'b1;
      endcase
    end
    else if (psel)
    begin
      next_s.rdata = s.rdata;
      next_s.err = s.err;
    end
  end

  function automatic logic [31:0] ZERO32_F();
    ZERO32_F = ect_pkg::ZERO32;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.cnt_limit <= ect_pkg::CNT_LIMIT_RST;
      s.tmr_len <= ect_pkg::TMR_LEN_RST;
      s.tmr_sel <= ect_pkg::TMR_ID_ONE;
      s.tmr_state <= ect_pkg::TMR_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pready = 1'b1;
  assign prdata = s.rdata;
  assign pslverr = s.err & psel & penable;
  assign count_done_event = s.cnt_done;
  assign tmr_done_event = s.tmr_done;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tick_spacing: assert property (s.tick |=> !s.tick [*8])
    else $error("tick too frequent");
  a_cmd_clear: assert property (cnt_cmd |=> s.cnt_value == '0 && s.cnt_run)
    else $error("clear command did not zero and run");
  a_clear_snap: assert property ((cnt_cmd || clr_fire) |=> s.cnt_snap == $past(s.cnt_value))
    else $error("snapshot wrong");
  a_src_clear_wait: assert property ((clr_fire && !cnt_cmd) |=> !s.cnt_run && s.cnt_value == '0)
    else $error("source clear did not stop counter");
  a_done_limit: assert property (s.cnt_done |-> s.cnt_value == s.cnt_limit)
    else $error("counter end not at limit");
  a_tmr_end: assert property (s.tmr_done |-> s.tmr_state == ect_pkg::TMR_DONE
                              && $past(s.tmr_state) == ect_pkg::TMR_RUN)
    else $error("timer end without completion");
  a_tmr_lock: assert property ($past(s.tmr_mode) |-> $stable(s.tmr_len) && $stable(s.tmr_src))
    else $error("timer config changed while active");
  a_tmr_clear: assert property ((tmr_cmd && s.tmr_mode && s.tmr_state == ect_pkg::TMR_RUN
                                 && s.tmr_src != ect_pkg::SRC_OFF)
                                |=> s.tmr_state == ect_pkg::TMR_ARMED && s.tmr_val == '0)
    else $error("timer clear did not rearm");
  a_line_strobe: assert property (rise[0] |=> !rise[0])
    else $error("line strobe longer than one cycle");

  c_cnt_done: cover property (s.cnt_done);
  c_tmr_done: cover property (s.tmr_done);
  c_src_clear: cover property (clr_fire && s.cnt_value != '0);
  c_tmr_clear: cover property (tmr_cmd && s.tmr_state == ect_pkg::TMR_RUN);

endmodule

// [dv/ect_partner.sv]
`timescale 1ns/10ps
// ==========================================================================
// Acquisition sequencer and input lines seen by the block
module ect_partner (
  input wire logic pclk, // Clock
  output logic [13:0] ev, // Bit n-1 is the pulse for source code n, 13 inc, 14 start
  output logic [1:0] line_in, // Input line levels
  output logic first, // Current frame is first of cycle
  output logic [3:0] cyc_set // Current cycling set
);
  initial
  begin
    ev = 14'h0000;
    line_in = 2'h0;
    first = 1'b0;
    cyc_set = 4'h0;
  end
  // Events are single-cycle pulses launched just after an edge
  task automatic pulse(input int code);
    @(posedge pclk);
    ev <= 14'h0001 << (code - 1);
    @(posedge pclk);
    ev <= 14'h0000;
  endtask
  task automatic set_line(input int idx, input logic lvl);
    @(posedge pclk);
    line_in[idx] <= lvl;
  endtask
  task automatic set_cycle(input logic f, input logic [3:0] s);
    @(posedge pclk);
    first <= f;
    cyc_set <= s;
  endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cnt_done, tmr_done, first;
  logic [13:0] ev;
  logic [1:0] line_in;
  logic [3:0] cyc_set;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam int TICKS = 10;
  always #2 pclk = ~pclk;
  ect_partner u_part (.pclk(pclk), .ev(ev), .line_in(line_in), .first(first),
    .cyc_set(cyc_set));
  ect_top #(.TICK_CYCLES(TICKS), .CYC_W(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .acq_start(ev[0]),
    .acq_end(ev[1]), .exp_start(ev[2]), .exp_end(ev[3]), .readout_start(ev[4]),
    .readout_end(ev[5]), .frame_start(ev[6]), .accepted_frame_trigger(ev[7]),
    .rejected_frame_trigger(ev[8]), .multi_frame_finish_event(ev[9]),
    .broadcast_cmd_one(ev[10]), .broadcast_cmd_two(ev[11]), .cycle_first_frame(first),
    .cycle_active_set(cyc_set), .count_inc_event(ev[12]), .count_start_event(ev[13]),
    .line_in(line_in), .count_done_event(cnt_done), .tmr_done_event(tmr_done));
  // ==========================================================================
  // Common tasks
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Setup cycle, then access until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(ect_pkg::ADDR_CNT_LIMIT, 32'h1);
    rd(ect_pkg::ADDR_TMR_SEL, 32'h1);
    rd(ect_pkg::ADDR_TMR_LEN, 32'h1);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h0);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h0);
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk(e, 32'h1);
    chk(q, 32'h0);
    $display("Test reset done");
  endtask
  task automatic t_count();
    wr(ect_pkg::ADDR_CNT_CTRL, 32'h2000);
    wr(ect_pkg::ADDR_CNT_LIMIT, 32'h3);
    wr(ect_pkg::ADDR_CNT_CMD, 32'h1);
    repeat (2) u_part.pulse(13);
    chk(cnt_done, 32'h0);
    u_part.pulse(13);
    @(posedge pclk);
    chk(cnt_done, 32'h1);
    @(posedge pclk);
    chk(cnt_done, 32'h0);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h3);
    wr(ect_pkg::ADDR_CNT_CMD, 32'h1);
    rd(ect_pkg::ADDR_CNT_SNAP, 32'h3);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h0);
    u_part.pulse(13);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h1);
    // Falling edge of line 1 is the clear source
    wr(ect_pkg::ADDR_CNT_CTRL, 32'h210D);
    u_part.set_line(0, 1'b1);
    repeat (5) @(posedge pclk);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h1);
    u_part.set_line(0, 1'b0);
    repeat (5) @(posedge pclk);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h0);
    rd(ect_pkg::ADDR_CNT_SNAP, 32'h1);
    u_part.pulse(13);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h0);
    u_part.pulse(14);
    u_part.pulse(13);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h1);
    $display("Test counter done");
  endtask
  task automatic t_timer();
    int n;
    wr(ect_pkg::ADDR_TMR_LEN, 32'h3);
    wr(ect_pkg::ADDR_TMR_CFG, 32'h71);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h1);
    u_part.pulse(7);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h2);
    n = 0;
    while (tmr_done !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk(tmr_done, 32'h1);
    @(posedge pclk);
    chk(tmr_done, 32'h0);
    rd(ect_pkg::ADDR_TMR_VALUE, 32'h3);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h3);
    wr(ect_pkg::ADDR_TMR_LEN, 32'h5);
    rd(ect_pkg::ADDR_TMR_LEN, 32'h3);
    u_part.pulse(7);
    wr(ect_pkg::ADDR_TMR_CMD, 32'h1);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h1);
    rd(ect_pkg::ADDR_TMR_VALUE, 32'h0);
    wr(ect_pkg::ADDR_TMR_CFG, 32'h70);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h0);
    wr(ect_pkg::ADDR_TMR_CFG, 32'h1);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h0);
    wr(ect_pkg::ADDR_TMR_CMD, 32'h1);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h2);
    wr(ect_pkg::ADDR_TMR_SEL, 32'h2);
    rd(ect_pkg::ADDR_TMR_LEN, 32'h0);
    wr(ect_pkg::ADDR_TMR_SEL, 32'h1);
    $display("Test timer done");
  endtask
  task automatic t_sources();
    int codes[11] = '{1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 12};
    foreach (codes[i])
    begin
      wr(ect_pkg::ADDR_TMR_CFG, 32'h0);
      wr(ect_pkg::ADDR_TMR_CFG, (32'(codes[i]) << 4) | 32'h1);
      u_part.pulse(codes[i]);
      rd(ect_pkg::ADDR_TMR_STATE, 32'h2);
    end
    // Line 2 falling edge starts, rising edge must not
    wr(ect_pkg::ADDR_TMR_CFG, 32'h0);
    wr(ect_pkg::ADDR_TMR_CFG, 32'h10E1);
    u_part.set_line(1, 1'b1);
    repeat (5) @(posedge pclk);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h1);
    u_part.set_line(1, 1'b0);
    repeat (5) @(posedge pclk);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h2);
    // Cycle source needs active set one
    wr(ect_pkg::ADDR_TMR_CFG, 32'h0);
    wr(ect_pkg::ADDR_TMR_CFG, 32'h111);
    u_part.set_cycle(1'b1, 4'h2);
    u_part.pulse(7);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h1);
    u_part.set_cycle(1'b1, 4'h1);
    u_part.pulse(7);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h2);
    // Rejected trigger is not a timer start source
    wr(ect_pkg::ADDR_TMR_CFG, 32'h0);
    wr(ect_pkg::ADDR_TMR_CFG, 32'h91);
    u_part.pulse(9);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h1);
    $display("Test sources done");
  endtask
  task automatic t_clear_src();
    int codes[2] = '{9, 10};
    // Rejected trigger and burst end as clear sources
    foreach (codes[i])
    begin
      wr(ect_pkg::ADDR_CNT_CTRL, 32'h2000 | 32'(codes[i]));
      wr(ect_pkg::ADDR_CNT_CMD, 32'h1);
      repeat (i + 1) u_part.pulse(13);
      u_part.pulse(codes[i]);
      rd(ect_pkg::ADDR_CNT_SNAP, 32'(i + 1));
      rd(ect_pkg::ADDR_CNT_VALUE, 32'h0);
    end
    // Counter end clears the counter and starts the timer
    wr(ect_pkg::ADDR_TMR_CFG, 32'h0);
    wr(ect_pkg::ADDR_TMR_CFG, 32'h101);
    wr(ect_pkg::ADDR_CNT_CTRL, 32'h2010);
    wr(ect_pkg::ADDR_CNT_LIMIT, 32'h2);
    wr(ect_pkg::ADDR_CNT_CMD, 32'h1);
    repeat (2) u_part.pulse(13);
    rd(ect_pkg::ADDR_TMR_STATE, 32'h2);
    rd(ect_pkg::ADDR_CNT_SNAP, 32'h2);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h0);
    // Timer end as clear source
    wr(ect_pkg::ADDR_TMR_CFG, 32'h0);
    wr(ect_pkg::ADDR_TMR_CFG, 32'h1);
    wr(ect_pkg::ADDR_CNT_CTRL, 32'h200F);
    wr(ect_pkg::ADDR_CNT_CMD, 32'h1);
    u_part.pulse(13);
    wr(ect_pkg::ADDR_TMR_CMD, 32'h1);
    repeat (4 * TICKS) @(posedge pclk);
    rd(ect_pkg::ADDR_CNT_SNAP, 32'h1);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h0);
    // Pause by increment select off
    wr(ect_pkg::ADDR_CNT_CMD, 32'h1);
    wr(ect_pkg::ADDR_CNT_CTRL, 32'h0);
    u_part.pulse(13);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h0);
    wr(ect_pkg::ADDR_CNT_CTRL, 32'h2000);
    u_part.pulse(13);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h1);
    // Tick increments: 30 sampled edges hold exactly three ticks
    wr(ect_pkg::ADDR_CNT_CTRL, 32'h1000);
    wr(ect_pkg::ADDR_CNT_CMD, 32'h1);
    repeat (3 * TICKS - 1) @(posedge pclk);
    rd(ect_pkg::ADDR_CNT_VALUE, 32'h3);
    $display("Test clear sources done");
  endtask
  // ==========================================================================
  // Timeout and main sequence
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count();
    t_timer();
    t_sources();
    t_clear_src();
    test_done();
  end
endmodule
